//--- hdl/mie_exec.sv
// Execution unit for rotate, move, bit, skip, branch, table and control ops.

// Overview of operation
// RULE_01 - Plain rotates take one cycle, keep flags, write memory or accumulator.
// RULE_02 - Rotates through carry take one cycle and change only carry.
// RULE_03 - Bit shifted out enters carry; old carry fills the vacated bit.
// RULE_04 - Moves copy memory, accumulator or immediate in one cycle, no flags.
// RULE_05 - Bit clear and set change only the chosen bit, one cycle.
// RULE_06 - Bit tests skip when bit is zero, or one for inverse form.
// RULE_07 - Increment or decrement and skip on zero result, no flags.
// RULE_08 - Test-and-move copies byte to accumulator, skips when it is zero.
// RULE_09 - Skips take two cycles when skipping, one otherwise.
// RULE_10 - A skipped instruction runs as a dummy cycle with no effect.
// RULE_11 - Writing the program counter low byte takes two cycles.
// RULE_12 - Jump, call and returns take two cycles; return-immediate loads it.
// RULE_13 - Call pushes incremented program counter and loads the target in the same cycle.
// RULE_14 - Table reads fetch current or last page word in two cycles.
// RULE_15 - Nibble swap exchanges halves, to memory or accumulator, one cycle.
// RULE_16 - Pre-clears clear timeout and power-down flags only when consecutive.
// RULE_17 - Halt enters power-down in one cycle and updates both flags.
module mie_exec #(
	parameter int PC_W = mie_pkg::PC_W,
	parameter int WORD_W = mie_pkg::WORD_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Decoded instruction
	input wire logic instr_valid,
	input wire logic [4:0] instr_op,
	input wire logic instr_to_acc,
	input wire logic [7:0] instr_addr,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_imm,
	input wire logic [PC_W-1:0] instr_target,
	input wire logic [PC_W-1:0] pc_current,
	// Data memory read, stack top, table pointer and program memory
	input wire logic [7:0] mem_rd_data,
	input wire logic [PC_W-1:0] stack_top,
	input wire logic [7:0] table_ptr,
	input wire logic [WORD_W-1:0] rom_rd_data,
	// Watchdog and wake events
	input wire logic watchdog_timeout_evt,
	input wire logic wake_evt,
	// Core state
	output logic [7:0] accumulator,
	output logic carry_flag,
	output logic watchdog_timeout_flag,
	output logic powerdown_flag,
	output logic [WORD_W-9:0] table_high_byte_reg,
	// Data memory write
	output logic mem_wr_en,
	output logic [7:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	// Program counter and stack
	output logic pc_load,
	output logic [PC_W-1:0] pc_load_addr,
	output logic stack_push,
	output logic [PC_W-1:0] stack_push_addr,
	output logic stack_pop,
	output logic int_enable_set,
	// Program memory read
	output logic rom_rd_en,
	output logic [PC_W-1:0] rom_rd_addr,
	// Control
	output logic watchdog_clear,
	output logic powerdown,
	output logic dummy_cycle
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	mie_pkg::mie_state_t state, next_state;
	mie_pkg::mie_pre_t pre, next_pre;
	logic [7:0] table_dest, next_table_dest;
	logic [7:0] next_accumulator;
	logic next_carry_flag;
	logic next_watchdog_timeout_flag;
	logic next_powerdown_flag;
	logic [WORD_W-9:0] next_table_high_byte_reg;
	logic next_mem_wr_en;
	logic [7:0] next_mem_wr_addr;
	logic [7:0] next_mem_wr_data;
	logic next_pc_load;
	logic [PC_W-1:0] next_pc_load_addr;
	logic next_stack_push;
	logic [PC_W-1:0] next_stack_push_addr;
	logic next_stack_pop;
	logic next_int_enable_set;
	logic next_rom_rd_en;
	logic [PC_W-1:0] next_rom_rd_addr;
	logic next_watchdog_clear;
	logic next_powerdown;
	logic next_dummy_cycle;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic [7:0] res;
		logic write_back;
		logic two_cycle;
		mie_pkg::mie_op_t op;
		res = mem_rd_data;
		write_back = 1'b0;
		two_cycle = 1'b0;
		op = mie_pkg::mie_op_t'(instr_op);
		next_state = mie_pkg::ST_EXEC;
		next_pre = pre;
		next_table_dest = table_dest;
		next_accumulator = accumulator;
		next_carry_flag = carry_flag;
		next_watchdog_timeout_flag = watchdog_timeout_flag;
		next_powerdown_flag = powerdown_flag;
		next_table_high_byte_reg = table_high_byte_reg;
		next_mem_wr_en = 1'b0;
		next_mem_wr_addr = instr_addr;
		next_mem_wr_data = mem_wr_data;
		next_pc_load = 1'b0;
		next_pc_load_addr = pc_load_addr;
		next_stack_push = 1'b0;
		next_stack_push_addr = stack_push_addr;
		next_stack_pop = 1'b0;
		next_int_enable_set = 1'b0;
		next_rom_rd_en = 1'b0;
		next_rom_rd_addr = rom_rd_addr;
		next_watchdog_clear = 1'b0;
		case (state)
			mie_pkg::ST_EXEC: begin
				if (instr_valid) begin
					next_pre = mie_pkg::PRE_NONE;
					case (op)
						mie_pkg::OP_ROT_RIGHT: begin
							res = {mem_rd_data[0], mem_rd_data[7:1]}; // RULE_01
							write_back = 1'b1;
						end
						mie_pkg::OP_ROT_LEFT: begin
							res = {mem_rd_data[6:0], mem_rd_data[7]}; // RULE_01
							write_back = 1'b1;
						end
						mie_pkg::OP_ROT_RIGHT_C: begin
							res = {carry_flag, mem_rd_data[7:1]}; // RULE_03
							next_carry_flag = mem_rd_data[0]; // RULE_02
							write_back = 1'b1;
						end
						mie_pkg::OP_ROT_LEFT_C: begin
							res = {mem_rd_data[6:0], carry_flag}; // RULE_03
							next_carry_flag = mem_rd_data[7]; // RULE_02
							write_back = 1'b1;
						end
						mie_pkg::OP_MOV_TO_ACC: begin
							next_accumulator = mem_rd_data; // RULE_04
						end
						mie_pkg::OP_MOV_TO_MEM: begin
							next_mem_wr_en = 1'b1; // RULE_04
							next_mem_wr_data = accumulator;
						end
						mie_pkg::OP_MOV_IMM: begin
							next_accumulator = instr_imm; // RULE_04
						end
						mie_pkg::OP_BIT_CLR: begin
							next_mem_wr_en = 1'b1;
							next_mem_wr_data = mem_rd_data &
								~(mie_pkg::BYTE_ONE << instr_bit); // RULE_05
						end
						mie_pkg::OP_BIT_SET: begin
							next_mem_wr_en = 1'b1;
							next_mem_wr_data = mem_rd_data |
								(mie_pkg::BYTE_ONE << instr_bit); // RULE_05
						end
						mie_pkg::OP_SKIP_BIT_ZERO: begin
							two_cycle = ~mem_rd_data[instr_bit]; // RULE_06
						end
						mie_pkg::OP_SKIP_BIT_NONZERO: begin
							two_cycle = mem_rd_data[instr_bit]; // RULE_06
						end
						mie_pkg::OP_SKIP_ZERO: begin
							two_cycle = (mem_rd_data == mie_pkg::BYTE_ZERO);
						end
						mie_pkg::OP_SKIP_ZERO_MOVE: begin
							next_accumulator = mem_rd_data; // RULE_08
							two_cycle = (mem_rd_data == mie_pkg::BYTE_ZERO); // RULE_08
						end
						mie_pkg::OP_INC_SKIP_ZERO: begin
							res = mem_rd_data + mie_pkg::BYTE_ONE; // RULE_07
							write_back = 1'b1;
							two_cycle = (res == mie_pkg::BYTE_ZERO); // RULE_07
						end
						mie_pkg::OP_DEC_SKIP_ZERO: begin
							res = mem_rd_data - mie_pkg::BYTE_ONE; // RULE_07
							write_back = 1'b1;
							two_cycle = (res == mie_pkg::BYTE_ZERO); // RULE_07
						end
						mie_pkg::OP_JUMP: begin
							next_pc_load = 1'b1;
							next_pc_load_addr = instr_target;
							two_cycle = 1'b1; // RULE_12
						end
						mie_pkg::OP_CALL: begin
							next_stack_push = 1'b1;
							next_stack_push_addr = pc_current +
								PC_W'(1); // RULE_13
							next_pc_load = 1'b1;
							next_pc_load_addr = instr_target; // RULE_13
							two_cycle = 1'b1; // RULE_12
						end
						mie_pkg::OP_RET, mie_pkg::OP_RET_IMM,
						mie_pkg::OP_RET_INT: begin
							next_stack_pop = 1'b1;
							next_pc_load = 1'b1;
							next_pc_load_addr = stack_top;
							if (op == mie_pkg::OP_RET_IMM) begin
								next_accumulator = instr_imm; // RULE_12
							end
							next_int_enable_set = (op == mie_pkg::OP_RET_INT);
							two_cycle = 1'b1; // RULE_12
						end
						mie_pkg::OP_TABLE_CUR, mie_pkg::OP_TABLE_LAST: begin
							next_rom_rd_en = 1'b1;
							next_rom_rd_addr = {pc_current[PC_W-1:8],
								table_ptr}; // RULE_14
							if (op == mie_pkg::OP_TABLE_LAST) begin
								next_rom_rd_addr = {{(PC_W-8){1'b1}},
									table_ptr}; // RULE_14
							end
							next_table_dest = instr_addr;
							next_state = mie_pkg::ST_TABLE; // RULE_14
						end
						mie_pkg::OP_MEM_CLR: begin
							next_mem_wr_en = 1'b1;
							next_mem_wr_data = mie_pkg::BYTE_ZERO;
						end
						mie_pkg::OP_MEM_SET: begin
							next_mem_wr_en = 1'b1;
							next_mem_wr_data = mie_pkg::BYTE_ONES;
						end
						mie_pkg::OP_WDT_CLR: begin
							next_watchdog_clear = 1'b1;
							next_watchdog_timeout_flag = 1'b0;
							next_powerdown_flag = 1'b0;
						end
						mie_pkg::OP_WDT_PRE_FIRST, mie_pkg::OP_WDT_PRE_SECOND: begin
							if ((op == mie_pkg::OP_WDT_PRE_FIRST &&
								pre == mie_pkg::PRE_SECOND) ||
								(op == mie_pkg::OP_WDT_PRE_SECOND &&
								pre == mie_pkg::PRE_FIRST)) begin
								next_watchdog_clear = 1'b1; // RULE_16
								next_watchdog_timeout_flag = 1'b0; // RULE_16
								next_powerdown_flag = 1'b0; // RULE_16
							end else if (op == mie_pkg::OP_WDT_PRE_FIRST) begin
								next_pre = mie_pkg::PRE_FIRST;
							end else begin
								next_pre = mie_pkg::PRE_SECOND;
							end
						end
						mie_pkg::OP_SWAP: begin
							res = {mem_rd_data[3:0], mem_rd_data[7:4]}; // RULE_15
							write_back = 1'b1;
						end
						mie_pkg::OP_HALT: begin
							next_watchdog_clear = 1'b1;
							next_watchdog_timeout_flag = 1'b0; // RULE_17
							next_powerdown_flag = 1'b1; // RULE_17
							next_state = mie_pkg::ST_HALT; // RULE_17
						end
						default: begin
						end
					endcase
					if (write_back) begin
						if (instr_to_acc) begin
							next_accumulator = res; // RULE_01
						end else begin
							next_mem_wr_en = 1'b1; // RULE_01
							next_mem_wr_data = res;
						end
					end
					if (next_mem_wr_en && instr_addr == mie_pkg::PCL_ADDR) begin
						two_cycle = 1'b1; // RULE_11
					end
					if (two_cycle) begin
						next_state = mie_pkg::ST_DUMMY; // RULE_09
					end
				end
			end
			mie_pkg::ST_DUMMY: begin
				next_state = mie_pkg::ST_EXEC; // RULE_10
			end
			mie_pkg::ST_TABLE: begin
				next_mem_wr_en = 1'b1;
				next_mem_wr_addr = table_dest;
				next_mem_wr_data = rom_rd_data[7:0]; // RULE_14
				next_table_high_byte_reg = rom_rd_data[WORD_W-1:8]; // RULE_14
				next_state = mie_pkg::ST_EXEC;
			end
			mie_pkg::ST_HALT: begin
				if (wake_evt) begin
					next_state = mie_pkg::ST_EXEC;
				end else begin
					next_state = mie_pkg::ST_HALT;
				end
			end
			default: begin
				next_state = mie_pkg::ST_EXEC;
			end
		endcase
		if (watchdog_timeout_evt) begin
			next_watchdog_timeout_flag = 1'b1;
		end
		next_powerdown = (next_state == mie_pkg::ST_HALT); // RULE_17
		next_dummy_cycle = (next_state == mie_pkg::ST_DUMMY ||
			next_state == mie_pkg::ST_TABLE); // RULE_10
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= mie_pkg::ST_EXEC;
			pre <= mie_pkg::PRE_NONE;
			table_dest <= mie_pkg::BYTE_ZERO;
			accumulator <= mie_pkg::BYTE_ZERO;
			carry_flag <= 1'b0;
			watchdog_timeout_flag <= 1'b0;
			powerdown_flag <= 1'b0;
			table_high_byte_reg <= '0;
			mem_wr_en <= 1'b0;
			mem_wr_addr <= mie_pkg::BYTE_ZERO;
			mem_wr_data <= mie_pkg::BYTE_ZERO;
			pc_load <= 1'b0;
			pc_load_addr <= '0;
			stack_push <= 1'b0;
			stack_push_addr <= '0;
			stack_pop <= 1'b0;
			int_enable_set <= 1'b0;
			rom_rd_en <= 1'b0;
			rom_rd_addr <= '0;
			watchdog_clear <= 1'b0;
			powerdown <= 1'b0;
			dummy_cycle <= 1'b0;
		end else begin
			state <= next_state;
			pre <= next_pre;
			table_dest <= next_table_dest;
			accumulator <= next_accumulator;
			carry_flag <= next_carry_flag;
			watchdog_timeout_flag <= next_watchdog_timeout_flag;
			powerdown_flag <= next_powerdown_flag;
			table_high_byte_reg <= next_table_high_byte_reg;
			mem_wr_en <= next_mem_wr_en;
			mem_wr_addr <= next_mem_wr_addr;
			mem_wr_data <= next_mem_wr_data;
			pc_load <= next_pc_load;
			pc_load_addr <= next_pc_load_addr;
			stack_push <= next_stack_push;
			stack_push_addr <= next_stack_push_addr;
			stack_pop <= next_stack_pop;
			int_enable_set <= next_int_enable_set;
			rom_rd_en <= next_rom_rd_en;
			rom_rd_addr <= next_rom_rd_addr;
			watchdog_clear <= next_watchdog_clear;
			powerdown <= next_powerdown;
			dummy_cycle <= next_dummy_cycle;
		end
	end

endmodule

//--- include/mie_pkg.sv
// Package with opcodes, states and constants of the instruction executor.
package mie_pkg;

	// ----------------------------------------
	// Widths and fixed values
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int PC_W = 12;
	localparam int WORD_W = 15;
	localparam int HIGH_W = WORD_W - DATA_W;
	localparam logic [7:0] PCL_ADDR = 8'h06;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ONES = 8'hff;

	// ----------------------------------------
	// Decoded operations from the fetch path
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ROT_RIGHT = 5'h01,
		OP_ROT_LEFT = 5'h02,
		OP_ROT_RIGHT_C = 5'h03,
		OP_ROT_LEFT_C = 5'h04,
		OP_MOV_TO_ACC = 5'h05,
		OP_MOV_TO_MEM = 5'h06,
		OP_MOV_IMM = 5'h07,
		OP_BIT_CLR = 5'h08,
		OP_BIT_SET = 5'h09,
		OP_SKIP_BIT_ZERO = 5'h0a,
		OP_SKIP_BIT_NONZERO = 5'h0b,
		OP_SKIP_ZERO = 5'h0c,
		OP_SKIP_ZERO_MOVE = 5'h0d,
		OP_INC_SKIP_ZERO = 5'h0e,
		OP_DEC_SKIP_ZERO = 5'h0f,
		OP_JUMP = 5'h10,
		OP_CALL = 5'h11,
		OP_RET = 5'h12,
		OP_RET_IMM = 5'h13,
		OP_RET_INT = 5'h14,
		OP_TABLE_CUR = 5'h15,
		OP_TABLE_LAST = 5'h16,
		OP_MEM_CLR = 5'h17,
		OP_MEM_SET = 5'h18,
		OP_WDT_CLR = 5'h19,
		OP_WDT_PRE_FIRST = 5'h1a,
		OP_WDT_PRE_SECOND = 5'h1b,
		OP_SWAP = 5'h1c,
		OP_HALT = 5'h1d
	} mie_op_t;

	// ----------------------------------------
	// Executor states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_DUMMY = 2'b01,
		ST_TABLE = 2'b10,
		ST_HALT = 2'b11
	} mie_state_t;

	// Last watchdog pre-clear seen, for the consecutive pair check.
	typedef enum logic [1:0] {
		PRE_NONE = 2'b00,
		PRE_FIRST = 2'b01,
		PRE_SECOND = 2'b10
	} mie_pre_t;

endpackage

//--- test/mie_exec_props.sv
// Checker with timing and result properties of the instruction executor.
module mie_exec_props #(
	parameter int PC_W = 12
) (
	// Clock, reset and instruction
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [4:0] instr_op,
	input wire logic instr_to_acc,
	input wire logic [7:0] instr_addr,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_imm,
	input wire logic [PC_W-1:0] instr_target,
	input wire logic [PC_W-1:0] pc_current,
	input wire logic [7:0] mem_rd_data,
	input wire logic watchdog_timeout_evt,
	// Results
	input wire logic [7:0] accumulator,
	input wire logic carry_flag,
	input wire logic watchdog_timeout_flag,
	input wire logic powerdown_flag,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wr_addr,
	input wire logic [7:0] mem_wr_data,
	input wire logic pc_load,
	input wire logic [PC_W-1:0] pc_load_addr,
	input wire logic stack_push,
	input wire logic [PC_W-1:0] stack_push_addr,
	input wire logic rom_rd_en,
	input wire logic powerdown,
	input wire logic dummy_cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tk;
	logic [4:0] op;
	logic [7:0] m;
	assign tk = instr_valid && !dummy_cycle && !powerdown;
	assign op = instr_op;
	assign m = mem_rd_data;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_rotl_acc_value: assert property (
		tk && op == mie_pkg::OP_ROT_LEFT && instr_to_acc |=>
		accumulator == {$past(m[6:0]), $past(m[7])} && !mem_wr_en
		&& $stable(carry_flag)) else $error("plain rotate wrong");
	a_rlc_mem_carry: assert property (
		tk && op == mie_pkg::OP_ROT_LEFT_C && !instr_to_acc |=>
		mem_wr_en && carry_flag == $past(m[7])
		&& mem_wr_data == {$past(m[6:0]), $past(carry_flag)})
		else $error("rotate through carry wrong");
	a_mov_imm_acc: assert property (
		tk && op == mie_pkg::OP_MOV_IMM |=>
		accumulator == $past(instr_imm) && !dummy_cycle)
		else $error("move immediate wrong");
	a_bit_set_one: assert property (
		tk && op == mie_pkg::OP_BIT_SET |=> mem_wr_en
		&& mem_wr_data == ($past(m) | (8'h01 << $past(instr_bit))))
		else $error("bit set wrong");
	a_skip_zero_taken: assert property (
		tk && op == mie_pkg::OP_SKIP_BIT_ZERO && !m[instr_bit] |=>
		dummy_cycle ##1 !dummy_cycle && !mem_wr_en && !pc_load)
		else $error("taken skip wrong");
	a_skip_nz_held: assert property (
		tk && op == mie_pkg::OP_SKIP_BIT_NONZERO && !m[instr_bit]
		|=> !dummy_cycle) else $error("skip not expected");
	a_call_push_pc: assert property (
		tk && op == mie_pkg::OP_CALL |=> pc_load && stack_push
		&& dummy_cycle && pc_load_addr == $past(instr_target)
		&& stack_push_addr == $past(pc_current) + 1'b1)
		else $error("call wrong");
	a_table_two_cyc: assert property (
		tk && (op == mie_pkg::OP_TABLE_CUR || op == mie_pkg::OP_TABLE_LAST)
		|=> rom_rd_en && dummy_cycle ##1 mem_wr_en
		&& mem_wr_addr == $past(instr_addr, 2))
		else $error("table read wrong");
	a_swap_acc_value: assert property (
		tk && op == mie_pkg::OP_SWAP && instr_to_acc |=>
		accumulator == {$past(m[3:0]), $past(m[7:4])} && !mem_wr_en)
		else $error("swap wrong");
	a_halt_flags_set: assert property (
		tk && op == mie_pkg::OP_HALT && !watchdog_timeout_evt |=>
		powerdown && powerdown_flag && !watchdog_timeout_flag)
		else $error("halt wrong");
	c_skip: cover property (tk && op == mie_pkg::OP_SKIP_BIT_ZERO);
	c_call: cover property (tk && op == mie_pkg::OP_CALL);
	c_halt: cover property (tk && op == mie_pkg::OP_HALT);
endmodule

//--- test/mie_exec_tb_top.sv
// Directed testbench of the instruction executor.
module mie_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PC_W = 12;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	logic [4:0] instr_op = 5'h00;
	logic instr_to_acc = 1'b0;
	logic [7:0] instr_addr = 8'h20;
	logic [2:0] instr_bit = 3'h0;
	logic [7:0] instr_imm = 8'h5a;
	logic [PC_W-1:0] instr_target = 12'h456;
	logic [PC_W-1:0] pc_current = 12'h123;
	logic [7:0] mem_rd_data = 8'h00;
	logic [PC_W-1:0] stack_top = 12'h321;
	logic [7:0] table_ptr = 8'h34;
	logic [mie_pkg::WORD_W-1:0] rom_rd_data = 15'h5abc;
	logic watchdog_timeout_evt = 1'b0;
	logic wake_evt = 1'b0;
	logic [7:0] accumulator, mem_wr_addr, mem_wr_data;
	logic [mie_pkg::WORD_W-9:0] table_high_byte_reg;
	logic [PC_W-1:0] pc_load_addr, stack_push_addr, rom_rd_addr;
	logic carry_flag, watchdog_timeout_flag, powerdown_flag, mem_wr_en;
	logic pc_load, stack_push, stack_pop, int_enable_set, rom_rd_en;
	logic watchdog_clear, powerdown, dummy_cycle;
	int fail_count = 0;
	int num_checks = 0;
	mie_exec #(.PC_W(PC_W), .WORD_W(mie_pkg::WORD_W)) u_dut (
		.ref_clk, .rst_b, .instr_valid, .instr_op, .instr_to_acc,
		.instr_addr, .instr_bit, .instr_imm, .instr_target, .pc_current,
		.mem_rd_data, .stack_top, .table_ptr, .rom_rd_data,
		.watchdog_timeout_evt, .wake_evt, .accumulator, .carry_flag,
		.watchdog_timeout_flag, .powerdown_flag, .table_high_byte_reg,
		.mem_wr_en, .mem_wr_addr, .mem_wr_data, .pc_load, .pc_load_addr,
		.stack_push, .stack_push_addr, .stack_pop, .int_enable_set,
		.rom_rd_en, .rom_rd_addr, .watchdog_clear, .powerdown, .dummy_cycle
	);
	always #10 ref_clk = ~ref_clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic issue(input mie_pkg::mie_op_t op, input logic acc,
		input logic [7:0] mem, input logic [2:0] b);
		instr_valid = 1'b1;
		instr_op = op;
		instr_to_acc = acc;
		mem_rd_data = mem;
		instr_bit = b;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic idle;
		instr_valid = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_rotate;
		issue(mie_pkg::OP_ROT_LEFT_C, 1'b0, 8'h81, 3'h0);
		chk("rlc data", 16'h0002, mem_wr_data);
		chk("rlc carry", 16'h0001, carry_flag);
		issue(mie_pkg::OP_ROT_LEFT, 1'b1, 8'h80, 3'h0);
		chk("rl acc", 16'h0001, accumulator);
		chk("rl carry", 16'h0001, carry_flag);
		chk("rl write", 16'h0000, mem_wr_en);
		issue(mie_pkg::OP_ROT_RIGHT_C, 1'b1, 8'h02, 3'h0);
		chk("rrc acc", 16'h0081, accumulator);
		chk("rrc carry", 16'h0000, carry_flag);
	endtask
	task automatic t_move;
		issue(mie_pkg::OP_MOV_IMM, 1'b0, 8'h00, 3'h0);
		chk("imm acc", 16'h005a, accumulator);
		issue(mie_pkg::OP_MOV_TO_MEM, 1'b0, 8'h00, 3'h0);
		chk("mov data", 16'h005a, mem_wr_data);
		chk("mov addr", 16'h0020, mem_wr_addr);
		issue(mie_pkg::OP_MOV_TO_ACC, 1'b0, 8'h3c, 3'h0);
		chk("mov acc", 16'h003c, accumulator);
		chk("mov carry", 16'h0000, carry_flag);
	endtask
	task automatic t_bits;
		issue(mie_pkg::OP_BIT_CLR, 1'b0, 8'hff, 3'h7);
		chk("clr bit", 16'h007f, mem_wr_data);
		issue(mie_pkg::OP_BIT_SET, 1'b0, 8'h00, 3'h0);
		chk("set bit", 16'h0001, mem_wr_data);
		issue(mie_pkg::OP_SWAP, 1'b1, 8'ha5, 3'h0);
		chk("swap acc", 16'h005a, accumulator);
		issue(mie_pkg::OP_ROT_RIGHT, 1'b0, 8'h01, 3'h0);
		chk("rr data", 16'h0080, mem_wr_data);
		issue(mie_pkg::OP_MEM_SET, 1'b0, 8'h00, 3'h0);
		chk("mem set", 16'h00ff, mem_wr_data);
		issue(mie_pkg::OP_MEM_CLR, 1'b0, 8'h00, 3'h0);
		chk("mem clr", 16'h0000, mem_wr_data);
	endtask
	task automatic skip_case(input mie_pkg::mie_op_t op, input logic acc,
		input logic [7:0] mem, input logic [2:0] b, input logic sk);
		logic [7:0] old;
		issue(op, acc, mem, b);
		chk("skip", {15'h0, sk}, dummy_cycle);
		old = accumulator;
		if (sk) begin
			issue(mie_pkg::OP_MOV_TO_ACC, 1'b0, ~old, 3'h0);
			chk("dummy acc", {8'h00, old}, accumulator);
			chk("dummy end", 16'h0000, dummy_cycle);
		end
	endtask
	task automatic t_skip;
		skip_case(mie_pkg::OP_SKIP_BIT_ZERO, 1'b0, 8'hfe, 3'h0, 1'b1);
		skip_case(mie_pkg::OP_SKIP_BIT_NONZERO, 1'b0, 8'hfe, 3'h0, 1'b0);
		skip_case(mie_pkg::OP_SKIP_BIT_NONZERO, 1'b0, 8'h80, 3'h7, 1'b1);
		skip_case(mie_pkg::OP_SKIP_ZERO_MOVE, 1'b0, 8'h00, 3'h0, 1'b1);
		skip_case(mie_pkg::OP_SKIP_ZERO_MOVE, 1'b0, 8'h9c, 3'h0, 1'b0);
		chk("move acc", 16'h009c, accumulator);
		skip_case(mie_pkg::OP_INC_SKIP_ZERO, 1'b1, 8'hff, 3'h0, 1'b1);
		chk("inc acc", 16'h0000, accumulator);
		skip_case(mie_pkg::OP_DEC_SKIP_ZERO, 1'b0, 8'h02, 3'h0, 1'b0);
		chk("dec data", 16'h0001, mem_wr_data);
		skip_case(mie_pkg::OP_SKIP_ZERO, 1'b0, 8'h00, 3'h0, 1'b1);
	endtask
	task automatic t_branch;
		mie_pkg::mie_op_t ops[4];
		ops = '{mie_pkg::OP_JUMP, mie_pkg::OP_RET, mie_pkg::OP_RET_INT,
			mie_pkg::OP_RET_IMM};
		issue(mie_pkg::OP_CALL, 1'b0, 8'h00, 3'h0);
		chk("call addr", 16'h0456, pc_load_addr);
		chk("push addr", 16'h0124, stack_push_addr);
		chk("call two", 16'h0001, dummy_cycle);
		idle;
		instr_imm = 8'h77;
		foreach (ops[i]) begin
			issue(ops[i], 1'b0, 8'h00, 3'h0);
			chk("branch two", 16'h0001, dummy_cycle);
			chk("branch addr", (ops[i] == mie_pkg::OP_JUMP) ? 16'h0456 :
				16'h0321, pc_load_addr);
			chk("branch pop", {15'h0, ops[i] != mie_pkg::OP_JUMP},
				stack_pop);
			chk("branch int", {15'h0, ops[i] == mie_pkg::OP_RET_INT},
				int_enable_set);
			idle;
		end
		chk("ret acc", 16'h0077, accumulator);
		instr_addr = mie_pkg::PCL_ADDR;
		issue(mie_pkg::OP_MOV_TO_MEM, 1'b0, 8'h00, 3'h0);
		chk("pcl two", 16'h0001, dummy_cycle);
		idle;
	endtask
	task automatic t_table(input mie_pkg::mie_op_t op, input logic [11:0] a);
		instr_addr = 8'h40;
		issue(op, 1'b0, 8'h00, 3'h0);
		chk("rom addr", {4'h0, a}, rom_rd_addr);
		idle;
		chk("tbl low", 16'h00bc, mem_wr_data);
		chk("tbl dest", 16'h0040, mem_wr_addr);
		chk("tbl high", 16'h005a, table_high_byte_reg);
	endtask
	task automatic t_wdt;
		watchdog_timeout_evt = 1'b1;
		idle;
		watchdog_timeout_evt = 1'b0;
		issue(mie_pkg::OP_WDT_PRE_FIRST, 1'b0, 8'h00, 3'h0);
		issue(mie_pkg::OP_NOP, 1'b0, 8'h00, 3'h0);
		issue(mie_pkg::OP_WDT_PRE_SECOND, 1'b0, 8'h00, 3'h0);
		issue(mie_pkg::OP_NOP, 1'b0, 8'h00, 3'h0);
		issue(mie_pkg::OP_WDT_PRE_FIRST, 1'b0, 8'h00, 3'h0);
		chk("pair apart", 16'h0001, watchdog_timeout_flag);
		chk("apart clear", 16'h0000, watchdog_clear);
		issue(mie_pkg::OP_WDT_PRE_SECOND, 1'b0, 8'h00, 3'h0);
		chk("pair done", 16'h0000, watchdog_timeout_flag);
		chk("pair clear", 16'h0001, watchdog_clear);
		watchdog_timeout_evt = 1'b1;
		idle;
		watchdog_timeout_evt = 1'b0;
		issue(mie_pkg::OP_WDT_CLR, 1'b0, 8'h00, 3'h0);
		chk("wdt clr", 16'h0000, watchdog_timeout_flag);
	endtask
	task automatic t_halt;
		issue(mie_pkg::OP_HALT, 1'b0, 8'h00, 3'h0);
		chk("halt pd", 16'h0001, powerdown);
		chk("halt flag", 16'h0001, powerdown_flag);
		chk("halt clr", 16'h0001, watchdog_clear);
		instr_imm = 8'hee;
		issue(mie_pkg::OP_MOV_IMM, 1'b0, 8'h00, 3'h0);
		chk("halt acc", 16'h0077, accumulator);
		wake_evt = 1'b1;
		idle;
		wake_evt = 1'b0;
		idle;
		chk("woken", 16'h0000, powerdown);
		issue(mie_pkg::OP_WDT_PRE_SECOND, 1'b0, 8'h00, 3'h0);
		chk("pd lone", 16'h0001, powerdown_flag);
		issue(mie_pkg::OP_WDT_PRE_FIRST, 1'b0, 8'h00, 3'h0);
		chk("pd pair", 16'h0000, powerdown_flag);
	endtask
	task automatic t_reset;
		instr_valid = 1'b0;
		rst_b = 1'b0;
		#1;
		chk("rst acc", 16'h0000, accumulator);
		chk("rst high", 16'h0000, table_high_byte_reg);
		@(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		issue(mie_pkg::OP_MOV_IMM, 1'b0, 8'h00, 3'h0);
		chk("rst imm", 16'h00ee, accumulator);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		t_rotate;
		t_move;
		t_bits;
		t_skip;
		t_branch;
		t_table(mie_pkg::OP_TABLE_CUR, 12'h134);
		t_table(mie_pkg::OP_TABLE_LAST, 12'hf34);
		t_wdt;
		t_halt;
		t_reset;
		stop_test;
	end
	initial begin
		#(400 * 20);
		fail_count++;
		stop_test;
	end
endmodule

bind mie_exec mie_exec_props #(.PC_W(PC_W)) u_props (
	.ref_clk, .rst_b, .instr_valid, .instr_op, .instr_to_acc, .instr_addr,
	.instr_bit, .instr_imm, .instr_target, .pc_current, .mem_rd_data,
	.watchdog_timeout_evt, .accumulator, .carry_flag,
	.watchdog_timeout_flag, .powerdown_flag, .mem_wr_en, .mem_wr_addr,
	.mem_wr_data, .pc_load, .pc_load_addr, .stack_push, .stack_push_addr,
	.rom_rd_en, .powerdown, .dummy_cycle
);
